/* File: verilog/tmsrp_consts.vh */
// Constants of the tag memory segment and read-protect logic.
// Assumes a 50 MHz clock and byte addresses on a 32-bit APB.
`ifndef TMSRP_CONSTS_VH
`define TMSRP_CONSTS_VH

`define TMSRP_ADDR_LAYOUT 8'h00
`define TMSRP_ADDR_STATUS 8'h04
`define TMSRP_ADDR_ACCPWD 8'h08
`define TMSRP_ADDR_HANDLE 8'h0C
`define TMSRP_ADDR_CONFIG 8'h10

`define TMSRP_VEIL_OPCODE 16'hE001
`define TMSRP_CRC_PRESET 16'hFFFF
`define TMSRP_CRC_POLY 16'h1021
`define TMSRP_CRC_RESIDUE 16'h1D0F
`define TMSRP_ERR_LOCKED 8'h04
`define TMSRP_ERR_OTHER 8'h00

`define TMSRP_TOTAL_BLOCKS 4'hA
`define TMSRP_MAX_ID_BLOCKS 4'h5
`define TMSRP_BLOCK_SHIFT 6
`define TMSRP_LAYOUT_RESET 16'h0000

`define TMSRP_ST_READY 3'h0
`define TMSRP_ST_ARBITRATE 3'h1
`define TMSRP_ST_REPLY 3'h2
`define TMSRP_ST_ACK 3'h3
`define TMSRP_ST_OPEN 3'h4
`define TMSRP_ST_SECURED 3'h5
`define TMSRP_ST_KILLED 3'h6

`define TMSRP_BANK_ID 2'h1
`define TMSRP_BANK_TID 2'h2
`define TMSRP_BANK_USER 2'h3

`define TMSRP_VERDICT_OK 2'h0
`define TMSRP_VERDICT_ABSENT 2'h1
`define TMSRP_VERDICT_HIDDEN 2'h2

`endif

/* File: verilog/tmsrp_top.v */
// Layout word, private area guard, password locator and veil command.
// Assumes decoded frames from the air front end, one clock, APB registers.
//
// Added by the designer: the register addresses and the APB slave port.
`include "tmsrp_consts.vh"

module tmsrp_top (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [2:0] tag_state,
	input wire acc_pwd_ok,
	input wire cmd_valid,
	input wire [47:0] cmd_frame,
	input wire unveil_done,
	input wire mem_lock_evt,
	input wire nvm_done,
	input wire nvm_err,
	input wire tx_done,
	input wire mem_req,
	input wire [1:0] mem_bank,
	input wire [9:0] mem_addr,
	output reg [1:0] mem_verdict,
	output reg mem_ack,
	output reg nvm_start,
	output reg reply_valid,
	output reg [32:0] reply_bits,
	output reg reply_ext_preamble,
	output reg reply_err,
	output reg [7:0] reply_err_code,
	output reg state_load,
	output reg [2:0] state_next,
	output reg id_code_read_lock_bit,
	output reg tag_identifier_read_lock_bit
);

	localparam S_IDLE = 2'h0;
	localparam S_NVM = 2'h1;
	localparam S_TX = 2'h2;

	reg [15:0] layout_q;
	reg layout_locked_q;
	reg layout_err_q;
	reg [31:0] acc_pwd_q;
	reg [15:0] handle_q;
	reg [1:0] fsm_q;
	reg [1:0] fsm_d;
	reg [32:0] reply_d;
	reg [15:0] crc_cmd;
	reg [15:0] crc_rep;
	reg [16:0] rep_head;
	reg veil_failed_q;
	integer i;
	integer k;

	wire [3:0] id_blocks = layout_q[11:8];
	wire [3:0] prot_blocks = layout_q[7:4];
	wire [3:0] priv_blocks = layout_q[3:0];
	wire [3:0] user_blocks = `TMSRP_TOTAL_BLOCKS - id_blocks;
	// Password start is the user area size in bits
	wire [9:0] pwd_addr = {user_blocks, 6'h00};
	wire [3:0] pub_blocks = user_blocks - priv_blocks;
	wire [9:0] priv_base = {pub_blocks, 6'h00};
	wire [9:0] user_end = {user_blocks, 6'h00};
	// Open count excludes only the protected and private blocks
	wire [3:0] open_blocks = `TMSRP_TOTAL_BLOCKS - prot_blocks - priv_blocks;

	wire secured = (tag_state == `TMSRP_ST_SECURED);
	wire bus_wr = psel && penable && pwrite && !pready;
	wire bus_rd = psel && penable && !pwrite && !pready;
	wire mapped = (paddr == `TMSRP_ADDR_LAYOUT) ||
		(paddr == `TMSRP_ADDR_STATUS) || (paddr == `TMSRP_ADDR_ACCPWD) ||
		(paddr == `TMSRP_ADDR_HANDLE) || (paddr == `TMSRP_ADDR_CONFIG);

	// Counts use the lower three nibbles; reserved nibble ignored
	wire [15:0] wr_layout = {4'h0, pwdata[11:0]};
	wire [5:0] wr_total = {2'h0, wr_layout[11:8]} +
		{2'h0, wr_layout[7:4]} + {2'h0, wr_layout[3:0]};
	wire wr_fits = (wr_total <= {2'h0, `TMSRP_TOTAL_BLOCKS}) &&
		(wr_layout[11:8] <= `TMSRP_MAX_ID_BLOCKS);
	wire layout_wr = bus_wr && (paddr == `TMSRP_ADDR_LAYOUT);
	wire layout_take = layout_wr && !layout_locked_q && secured &&
		wr_fits;

	// CRC-16 over frame body; residue check catches any bad bit
	always @* begin
		crc_cmd = `TMSRP_CRC_PRESET;
		for (i = 47; i >= 0; i = i - 1) begin
			if (crc_cmd[15] ^ cmd_frame[i]) begin
				crc_cmd = {crc_cmd[14:0], 1'b0} ^ `TMSRP_CRC_POLY;
			end else begin
				crc_cmd = {crc_cmd[14:0], 1'b0};
			end
		end
	end

	// Reply CRC over the 0 header and the handle
	always @* begin
		rep_head = {1'b0, handle_q};
		crc_rep = `TMSRP_CRC_PRESET;
		for (k = 16; k >= 0; k = k - 1) begin
			if (crc_rep[15] ^ rep_head[k]) begin
				crc_rep = {crc_rep[14:0], 1'b0} ^ `TMSRP_CRC_POLY;
			end else begin
				crc_rep = {crc_rep[14:0], 1'b0};
			end
		end
		reply_d = {rep_head, ~crc_rep};
	end

	wire crc_ok = (crc_cmd == `TMSRP_CRC_RESIDUE);
	wire is_veil = (cmd_frame[47:32] == `TMSRP_VEIL_OPCODE);
	wire handle_ok = (cmd_frame[31:16] == handle_q);
	wire pwd_zero = (acc_pwd_q == 32'h00000000);
	wire veil_in = cmd_valid && is_veil && crc_ok && (fsm_q == S_IDLE) &&
		!pwd_zero;
	wire veil_go = veil_in && secured && handle_ok && acc_pwd_ok;

	always @* begin
		fsm_d = fsm_q;
		case (fsm_q)
			S_IDLE: begin
				if (veil_go) begin
					fsm_d = S_NVM;
				end
			end
			S_NVM: begin
				if (nvm_done) begin
					fsm_d = S_TX;
				end
			end
			S_TX: begin
				if (tx_done) begin
					fsm_d = S_IDLE;
				end
			end
			default: begin
				fsm_d = S_IDLE;
			end
		endcase
	end

	// Veil command sequencing and reply
	always @(posedge clk) begin
		if (srst) begin
			fsm_q <= S_IDLE;
			nvm_start <= 1'b0;
			reply_valid <= 1'b0;
			reply_bits <= 33'h000000000;
			reply_ext_preamble <= 1'b0;
			reply_err <= 1'b0;
			reply_err_code <= 8'h00;
			state_load <= 1'b0;
			state_next <= `TMSRP_ST_READY;
		end else begin
			fsm_q <= fsm_d;
			nvm_start <= veil_go;
			reply_valid <= 1'b0;
			reply_err <= 1'b0;
			state_load <= 1'b0;
			if (veil_in && !secured) begin
				// Silent; only the inventory states fall back
				if (tag_state == `TMSRP_ST_ARBITRATE ||
					tag_state == `TMSRP_ST_REPLY ||
					tag_state == `TMSRP_ST_ACK) begin
					state_load <= 1'b1;
					state_next <= `TMSRP_ST_ARBITRATE;
				end
			end else if (veil_in && handle_ok && !acc_pwd_ok) begin
				state_load <= 1'b1;
				state_next <= `TMSRP_ST_ARBITRATE;
			end
			if (fsm_q == S_NVM && nvm_done) begin
				reply_ext_preamble <= 1'b1;
				if (nvm_err) begin
					reply_err <= 1'b1;
					reply_err_code <= `TMSRP_ERR_OTHER;
				end else begin
					reply_valid <= 1'b1;
					reply_bits <= reply_d;
				end
			end
		end
	end

	// Read-lock bits are set only after the success reply is sent; unveil_done clears them unless that set comes in the same cycle
	always @(posedge clk) begin
		if (srst) begin
			id_code_read_lock_bit <= 1'b0;
			tag_identifier_read_lock_bit <= 1'b0;
		end else if (fsm_q == S_TX && tx_done && !veil_failed_q) begin
			// An error reply leaves both bits alone
			id_code_read_lock_bit <= 1'b1;
			tag_identifier_read_lock_bit <= 1'b1;
		end else if (unveil_done) begin
			id_code_read_lock_bit <= 1'b0;
			tag_identifier_read_lock_bit <= 1'b0;
		end
	end

	// Error reply leaves the sequencer waiting for its transmission too
	always @(posedge clk) begin
		if (srst) begin
			veil_failed_q <= 1'b0;
		end else if (fsm_q == S_NVM && nvm_done) begin
			veil_failed_q <= nvm_err;
		end
	end

	// Layout word, one-time programming and auto lock
	always @(posedge clk) begin
		if (srst) begin
			layout_q <= `TMSRP_LAYOUT_RESET;
			layout_locked_q <= 1'b0;
			layout_err_q <= 1'b0;
		end else begin
			if (layout_take) begin
				layout_q <= wr_layout;
				layout_locked_q <= 1'b1;
			end else if (mem_lock_evt) begin
				layout_locked_q <= 1'b1;
			end
			// Set beats a clear arriving in the same cycle
			if (layout_wr && !layout_locked_q && secured && !wr_fits) begin
				layout_err_q <= 1'b1;
			end else if (bus_wr && paddr == `TMSRP_ADDR_STATUS &&
				pwdata[3]) begin
				layout_err_q <= 1'b0;
			end
		end
	end

	// APB registers: answer one cycle into the access phase
	always @(posedge clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			acc_pwd_q <= 32'h00000000;
			handle_q <= 16'h0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready &&
				(!mapped || (layout_wr && (layout_locked_q || !secured ||
				!wr_fits)));
			if (bus_wr && paddr == `TMSRP_ADDR_ACCPWD) begin
				acc_pwd_q <= pwdata;
			end
			if (bus_wr && paddr == `TMSRP_ADDR_HANDLE) begin
				handle_q <= pwdata[15:0];
			end
			if (bus_rd) begin
				case (paddr)
					`TMSRP_ADDR_LAYOUT: prdata <= {16'h0000, layout_q};
					`TMSRP_ADDR_STATUS: prdata <= {6'h00, pwd_addr, 4'h0,
						open_blocks, veil_failed_q, fsm_q, 1'b0,
						layout_err_q, tag_identifier_read_lock_bit,
						id_code_read_lock_bit, layout_locked_q};
					`TMSRP_ADDR_ACCPWD: prdata <= acc_pwd_q;
					`TMSRP_ADDR_HANDLE: prdata <= {16'h0000, handle_q};
					`TMSRP_ADDR_CONFIG: prdata <= {30'h00000000,
						tag_identifier_read_lock_bit, id_code_read_lock_bit};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Memory access verdicts, one cycle after the request
	always @(posedge clk) begin
		if (srst) begin
			mem_ack <= 1'b0;
			mem_verdict <= `TMSRP_VERDICT_OK;
		end else begin
			mem_ack <= mem_req;
			if (mem_req) begin
				if (mem_bank == `TMSRP_BANK_USER &&
					(mem_addr >= user_end ||
					(mem_addr >= priv_base && !secured))) begin
					mem_verdict <= `TMSRP_VERDICT_ABSENT;
				end else if ((mem_bank == `TMSRP_BANK_ID &&
					id_code_read_lock_bit) ||
					(mem_bank == `TMSRP_BANK_TID &&
					tag_identifier_read_lock_bit)) begin
					mem_verdict <= `TMSRP_VERDICT_HIDDEN;
				end else begin
					mem_verdict <= `TMSRP_VERDICT_OK;
				end
			end
		end
	end

endmodule // tmsrp_top

/* File: verification/tmsrp_rdr.sv */
// Interrogator model: sends veil frames, ends NVM writes and replies.
// Assumes send is called just after a rising edge of clk.
module tmsrp_rdr (
	input wire logic clk,
	input wire logic nvm_start,
	input wire logic reply_valid,
	input wire logic reply_err,
	input wire logic fail,
	input wire logic [3:0] lat,
	output logic cmd_valid,
	output logic [47:0] cmd_frame,
	output logic nvm_done,
	output logic nvm_err,
	output logic tx_done
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [15:0] crc16(input logic [32:0] d, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ (c[15] ^ d[i] ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	// Frame-sync is implied ahead of every frame; bad spoils the CRC
	task automatic send(input logic [15:0] h, input logic bad);
		logic [15:0] c;
		c = ~crc16({1'h0, 16'hE001, h}, 32) ^ {15'h0, bad};
		cmd_frame <= {16'hE001, h, c};
		cmd_valid <= 1'h1;
		@(posedge clk);
		cmd_valid <= 1'h0;
		cmd_frame <= ~{16'hE001, h, c};
	endtask
	// Latency lat models both a prompt and a slow far side
	initial begin
		logic s;
		cmd_valid = 1'h0;
		cmd_frame = 48'h0;
		nvm_done = 1'h0;
		nvm_err = 1'h0;
		tx_done = 1'h0;
		forever begin
			@(posedge clk);
			s = nvm_start;
			if (s || reply_valid || reply_err) begin
				repeat (lat) @(posedge clk);
				nvm_done <= s;
				nvm_err <= s & fail;
				tx_done <= !s;
				@(posedge clk);
				nvm_done <= 1'h0;
				nvm_err <= 1'h0;
				tx_done <= 1'h0;
			end
		end
	end
endmodule // tmsrp_rdr

/* File: verification/tmsrp_top_props.sv */
// Checker on the ports of tmsrp_top.
// Assumes one clock and the synchronous reset srst.
`include "tmsrp_consts.vh"
module tmsrp_chk (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire [7:0] paddr,
	input wire [2:0] tag_state,
	input wire cmd_valid,
	input wire tx_done,
	input wire unveil_done,
	input wire mem_req,
	input wire mem_ack,
	input wire nvm_start,
	input wire reply_valid,
	input wire reply_ext_preamble,
	input wire [32:0] reply_bits,
	input wire id_code_read_lock_bit,
	input wire tag_identifier_read_lock_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	unmapped_err_a: assert property
		(psel && penable && !pready && paddr > 8'h10 |=> pslverr)
		else $error("no error on unmapped address");
	veil_gate_a: assert property
		(cmd_valid && tag_state != `TMSRP_ST_SECURED |=> !nvm_start)
		else $error("veil started outside secured");
	lock_timing_a: assert property
		($rose(id_code_read_lock_bit) |-> $past(tx_done))
		else $error("read lock before reply end");
	lock_pair_a: assert property
		(id_code_read_lock_bit == tag_identifier_read_lock_bit)
		else $error("read lock bits differ");
	unveil_clear_a: assert property (unveil_done |=>
		!id_code_read_lock_bit && !tag_identifier_read_lock_bit)
		else $error("unveil left locks set");
	preamble_a: assert property (reply_valid |-> reply_ext_preamble)
		else $error("short preamble");
	reply_header_a: assert property (reply_valid |-> !reply_bits[32])
		else $error("reply header not zero");
	mem_answer_a: assert property (mem_req |=> mem_ack)
		else $error("memory check not answered");
	cover property (reply_valid);
	cover property (pready && pslverr);
	cover property ($rose(id_code_read_lock_bit));
endmodule // tmsrp_chk
bind tmsrp_top tmsrp_chk i_chk (.clk, .srst, .psel, .penable, .pready,
	.pslverr, .paddr, .tag_state, .cmd_valid, .tx_done, .unveil_done,
	.mem_req, .mem_ack, .nvm_start, .reply_valid, .reply_ext_preamble,
	.reply_bits, .id_code_read_lock_bit, .tag_identifier_read_lock_bit);

/* File: verification/tmsrp_top_tb.sv */
// Bench for layout word, private guard and veil command.
// Assumes the interrogator model and the bound checker.
`include "tmsrp_consts.vh"
module tmsrp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, acc_pwd_ok = 1'h0, unveil_done = 1'h0;
	logic mem_lock_evt = 1'h0, mem_req = 1'h0, fail = 1'h0;
	logic [7:0] paddr = 8'h00, reply_err_code;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [2:0] tag_state = 3'h0, state_next, got_st;
	logic [1:0] mem_bank = 2'h0, mem_verdict;
	logic [9:0] mem_addr = 10'h000;
	logic [3:0] lat = 4'h1;
	logic [47:0] cmd_frame;
	logic [32:0] reply_bits, rep;
	logic pready, pslverr, cmd_valid, nvm_done, nvm_err, tx_done, mem_ack;
	logic nvm_start, reply_valid, reply_ext_preamble, reply_err, state_load;
	logic id_code_read_lock_bit, tag_identifier_read_lock_bit;
	logic got_nvm, got_err, got_rep;
	int miscompares = 0, checked = 0;
	wire [1:0] locks = {id_code_read_lock_bit, tag_identifier_read_lock_bit};
	logic [15:0] lay [3] = '{16'h0043, 16'h0030, 16'h0106};
	logic [9:0] pwa [3] = '{10'h280, 10'h280, 10'h240};
	logic [3:0] opn [3] = '{4'h3, 4'h7, 4'h4};
	tmsrp_top i_dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .tag_state, .acc_pwd_ok, .cmd_valid,
		.cmd_frame, .unveil_done, .mem_lock_evt, .nvm_done, .nvm_err,
		.tx_done, .mem_req, .mem_bank, .mem_addr, .mem_verdict, .mem_ack,
		.nvm_start, .reply_valid, .reply_bits, .reply_ext_preamble,
		.reply_err, .reply_err_code, .state_load, .state_next,
		.id_code_read_lock_bit, .tag_identifier_read_lock_bit);
	tmsrp_rdr i_rdr (.clk, .nvm_start, .reply_valid, .reply_err, .fail,
		.lat, .cmd_valid, .cmd_frame, .nvm_done, .nvm_err, .tx_done);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (nvm_start) got_nvm <= 1'h1;
		if (reply_err) got_err <= 1'h1;
		if (reply_valid) got_rep <= 1'h1;
		if (reply_valid) rep <= reply_bits;
		if (state_load) got_st <= state_next;
	end
	task automatic tally_and_finish();
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// Release lands on the same edge pready is seen, so no double drive
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			tally_and_finish();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
		chk(e, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		chk(q, x);
	endtask
	task automatic rst();
		srst <= 1'h1;
		repeat (16) @(posedge clk);
		srst <= 1'h0;
	endtask
	task automatic mem(input logic [1:0] b, input logic [9:0] a,
		input logic [1:0] v);
		mem_bank <= b;
		mem_addr <= a;
		mem_req <= 1'h1;
		@(posedge clk);
		mem_req <= 1'h0;
		repeat (2) @(posedge clk);
		chk(mem_verdict, v);
	endtask
	// Fixed wait stands in for the interrogator's reply timeout
	task automatic veil(input logic [15:0] h, input logic bad);
		got_nvm = 1'h0;
		got_err = 1'h0;
		got_rep = 1'h0;
		got_st = 3'h7;
		i_rdr.send(h, bad);
		repeat (40) @(posedge clk);
	endtask
	initial begin
		rst();
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		wr(8'h14, 32'h1, 1'h1);
		tag_state <= 3'h4;
		wr(8'h00, 32'h0043, 1'h1);
		tag_state <= `TMSRP_ST_SECURED;
		wr(8'h00, 32'h0087, 1'h1);
		rd(8'h04, {6'h0, 10'h280, 4'h0, 4'hA, 8'h08});
		wr(8'h00, 32'h0600, 1'h1);
		for (int i = 0; i < 3; i++) begin
			rst();
			wr(8'h00, {16'h0, 4'hF, lay[i][11:0]}, 1'h0);
			rd(8'h00, {16'h0, lay[i]});
			rd(8'h04, {6'h0, pwa[i], 4'h0, opn[i], 8'h01});
			wr(8'h00, 32'h0030, 1'h1);
			rd(8'h00, {16'h0, lay[i]});
		end
		tag_state <= 3'h4;
		mem(2'h3, 10'h0C8, 2'h1);
		mem(2'h3, 10'h064, 2'h0);
		tag_state <= `TMSRP_ST_SECURED;
		mem(2'h3, 10'h0C8, 2'h0);
		mem(2'h3, 10'h258, 2'h1);
		rst();
		mem_lock_evt <= 1'h1;
		@(posedge clk);
		mem_lock_evt <= 1'h0;
		wr(8'h00, 32'h0043, 1'h1);
		rd(8'h04, {6'h0, 10'h280, 4'h0, 4'hA, 8'h01});
		wr(8'h0C, 32'h0000BEEF, 1'h0);
		veil(16'hBEEF, 1'h0);
		chk({got_nvm, got_st}, 4'h7);
		wr(8'h08, 32'h12345678, 1'h0);
		acc_pwd_ok <= 1'h1;
		veil(16'hBEEF, 1'h1);
		chk({got_nvm, got_st}, 4'h7);
		veil(16'h1111, 1'h0);
		chk({got_nvm, got_st}, 4'h7);
		fail <= 1'h1;
		veil(16'hBEEF, 1'h0);
		chk({got_err, got_rep, reply_err_code, locks}, 12'h800);
		fail <= 1'h0;
		lat <= 4'h6;
		veil(16'hBEEF, 1'h0);
		chk(rep, {1'h0, 16'hBEEF, ~i_rdr.crc16({17'h0, 16'hBEEF}, 17)});
		chk({got_rep, locks, got_st}, 6'h3F);
		rd(8'h10, 32'h3);
		mem(2'h1, 10'h000, 2'h2);
		mem(2'h3, 10'h000, 2'h0);
		unveil_done <= 1'h1;
		@(posedge clk);
		unveil_done <= 1'h0;
		@(posedge clk);
		chk(locks, 2'h0);
		acc_pwd_ok <= 1'h0;
		veil(16'hBEEF, 1'h0);
		chk({got_nvm, got_st}, 4'h1);
		acc_pwd_ok <= 1'h1;
		for (int s = 0; s < 7; s++) if (s != 5) begin
			tag_state <= s[2:0];
			veil(16'hBEEF, 1'h0);
			chk({got_nvm, got_st}, (s >= 1 && s <= 3) ? 4'h1 : 4'h7);
		end
		tally_and_finish();
	end
endmodule // tmsrp_top_tb
